//--- design/pmc_mfr_regs.sv
//////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pmc_mfr_regs #(
  parameter logic [15:0] FW_REV    = 16'h0000, // arbitrary value
  parameter logic [5:0]  MOD_NAME  = 6'h00     // arbitrary value
) (
  input  wire logic            clk_sys,       // 125 mhz clock
  input  wire logic            rst,           // async reset, active high
  input  wire logic            wr_byte,       // one write data byte strobe
  input  wire logic            wr_end,        // end of write transaction
  input  wire pmc_pkg::pmc_wr_s wr,           // command, byte index, byte
  input  wire logic [7:0]      rd_cmd,        // command being read
  input  wire logic [3:0]      rd_idx,        // byte index being read
  input  wire logic            fault_clear,   // clear faults pulse
  input  wire logic            alert_active,  // smbalert asserted
  input  wire logic [7:0]      strap_addr,    // resistor programmed address
  input  wire logic            power_good_out_int,     // internal power good
  output logic [7:0]           rd_data,       // read byte
  output logic [7:0]           resp_addr,     // address to answer
  output logic                 power_good_out,// power-good pin level
  output logic                 write_protect_on, // protection state
  output logic                 inv_data,      // comm_status_byte invalid-data
  output logic [15:0]          vout_gain,     // calibration outputs
  output logic [15:0]          vout_ofs,      // vout offset
  output logic [15:0]          vin_gain,      // vin gain
  output logic [15:0]          vin_ofs,       // vin offset
  output logic [15:0]          iout_gain,     // iout gain
  output logic [15:0]          iout_ofs       // iout offset
);

  //////////////////////////////////////////////////////////////////////////////////////////
  logic [15:0] word_q, word_d;
  logic        bad_q, bad_d;
  logic        wpe_q, wpe_d;
  logic [7:0]  ara_q, ara_d;
  logic [7:0]  pol_q, pol_d;
  logic        inv_q, inv_d;
  logic [15:0] cal_q [6];
  logic [15:0] cal_d [6];
  logic [7:0]  dls_q [pmc_pkg::DLS_BYTES];
  logic [7:0]  dls_d [pmc_pkg::DLS_BYTES];
  logic        ok;
  logic        prot;
  logic [2:0]  ci;
  logic        is_cal;

  pmc_cal_check u_chk (
    .cmd   (wr.cmd),
    .word  (word_q),
    .valid (ok)
  );

  always_comb begin
    is_cal = 1'b1;
    ci     = 3'd0;
    unique case (wr.cmd)
      pmc_pkg::CMD_VOUT_GAIN: ci = 3'd0;
      pmc_pkg::CMD_VOUT_OFS:  ci = 3'd1;
      pmc_pkg::CMD_VIN_GAIN:  ci = 3'd2;
      pmc_pkg::CMD_VIN_OFS:   ci = 3'd3;
      pmc_pkg::CMD_IOUT_GAIN: ci = 3'd4;
      pmc_pkg::CMD_IOUT_OFS:  ci = 3'd5;
      default:                is_cal = 1'b0;
    endcase
  end

  // protected commands: calibration and identity block
  assign prot = is_cal || (wr.cmd == pmc_pkg::CMD_DLS);

  //////////////////////////////////////////////////////////////////////////////////////////
  // words assemble low byte first; committed only at the end of the transaction so a
  // torn write never reaches the calibration path
  always_comb begin
    word_d = word_q;
    bad_d  = bad_q;
    wpe_d  = wpe_q;
    ara_d  = ara_q;
    pol_d  = pol_q;
    inv_d  = inv_q;
    cal_d  = cal_q;
    dls_d  = dls_q;
    if (wr_byte) begin
      if (wr.idx == 4'd0) begin
        word_d[7:0] = wr.data;
        bad_d       = 1'b0;
      end else if (wr.idx == 4'd1) begin
        word_d[15:8] = wr.data;
      end
      if ((wr.cmd == pmc_pkg::CMD_DLS) && !wpe_q) begin
        if (wr.idx < 4'(pmc_pkg::DLS_BYTES)) begin
          dls_d[wr.idx] = wr.data;
        end else begin
          bad_d = 1'b1;
        end
      end
    end
    if (fault_clear) begin
      inv_d = 1'b0;
    end
    if (wr_end) begin
      // an out-of-range block index must not poison the next block write
      bad_d = 1'b0;
      if (prot && wpe_q) begin
        inv_d = inv_d;
      end else if (is_cal) begin
        if (ok) begin
          cal_d[ci] = word_q;
        end else begin
          inv_d = 1'b1;
        end
      end else if (wr.cmd == pmc_pkg::CMD_DEV_TYPE) begin
        wpe_d = word_q[pmc_pkg::WPE_BIT];
      end else if (wr.cmd == pmc_pkg::CMD_ARA_CFG) begin
        ara_d = word_q[7:0] & pmc_pkg::ARA_MASK;
      end else if (wr.cmd == pmc_pkg::CMD_PG_POL) begin
        pol_d = {7'h00, word_q[pmc_pkg::PG_POL_BIT]};
      end else if (wr.cmd == pmc_pkg::CMD_FW_REV) begin
        inv_d = 1'b1;
      end else if ((wr.cmd == pmc_pkg::CMD_DLS) && bad_q) begin
        inv_d = 1'b1;
      end
    end
  end

  // set wins over fault clear since the set is applied last
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_q <= 16'h0000;
      bad_q  <= 1'b0;
      wpe_q  <= 1'b0;
      ara_q  <= pmc_pkg::ARA_RST;
      pol_q  <= pmc_pkg::PG_POL_RST;
      inv_q  <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        cal_q[i] <= i[0] ? pmc_pkg::OFS_RST : pmc_pkg::GAIN_RST;
      end
      for (int i = 0; i < pmc_pkg::DLS_BYTES; i++) begin
        dls_q[i] <= 8'h00;
      end
    end else begin
      word_q <= word_d;
      bad_q  <= bad_d;
      wpe_q  <= wpe_d;
      ara_q  <= ara_d;
      pol_q  <= pol_d;
      inv_q  <= inv_d;
      cal_q  <= cal_d;
      dls_q  <= dls_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  logic [15:0] rword;
  always_comb begin
    rword = 16'h0000;
    unique case (rd_cmd)
      pmc_pkg::CMD_DEV_TYPE:  rword = {8'h00, MOD_NAME, wpe_q, 1'b0};
      pmc_pkg::CMD_VOUT_GAIN: rword = cal_q[0];
      pmc_pkg::CMD_VOUT_OFS:  rword = cal_q[1];
      pmc_pkg::CMD_VIN_GAIN:  rword = cal_q[2];
      pmc_pkg::CMD_VIN_OFS:   rword = cal_q[3];
      pmc_pkg::CMD_IOUT_GAIN: rword = cal_q[4];
      pmc_pkg::CMD_IOUT_OFS:  rword = cal_q[5];
      pmc_pkg::CMD_FW_REV:    rword = FW_REV;
      pmc_pkg::CMD_ARA_CFG:   rword = {8'h00, ara_q};
      pmc_pkg::CMD_PG_POL:    rword = {8'h00, pol_q};
      default:                rword = 16'h0000;
    endcase
    if (rd_cmd == pmc_pkg::CMD_DLS) begin
      rd_data = (rd_idx < 4'(pmc_pkg::DLS_BYTES)) ? dls_q[rd_idx] : 8'h00;
    end else begin
      rd_data = rd_idx[0] ? rword[15:8] : rword[7:0];
    end
  end

  // alert response address only while alert is up and enabled
  assign resp_addr = (ara_q[pmc_pkg::ARA_BIT] && alert_active) ?
                     pmc_pkg::SMB_ARA_ADDR : strap_addr;
  assign power_good_out   = pol_q[pmc_pkg::PG_POL_BIT] ? power_good_out_int : !power_good_out_int;
  assign write_protect_on = wpe_q;
  assign inv_data  = inv_q;
  assign vout_gain = cal_q[0];
  assign vout_ofs  = cal_q[1];
  assign vin_gain  = cal_q[2];
  assign vin_ofs   = cal_q[3];
  assign iout_gain = cal_q[4];
  assign iout_ofs  = cal_q[5];

  //////////////////////////////////////////////////////////////////////////////////////////
  // whole calibration set is compared, since the command and its index move on
  // once the transaction is over
  prot_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && is_cal && wpe_q)
    |=> $stable({vout_gain, vout_ofs, vin_gain, vin_ofs, iout_gain, iout_ofs}))
    else $error("protected calibration write took effect");
  prot_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && prot && wpe_q && !inv_q && !fault_clear) |=> !inv_q)
    else $error("locked write raised invalid data");
  gain_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (vout_gain >= 16'h1999) && (vout_gain <= 16'h2666))
    else $error("vout gain left its range");
  ofs_exp_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && !wpe_q && wr.cmd == pmc_pkg::CMD_VIN_OFS && word_q[15:11] != 5'h1d)
    |=> inv_q && $stable(vin_ofs))
    else $error("bad vin offset exponent accepted");
  fw_ro_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_cmd == pmc_pkg::CMD_FW_REV && !rd_idx[0]) |-> rd_data == FW_REV[7:0])
    else $error("firmware revision low byte wrong");
  fw_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_cmd == pmc_pkg::CMD_FW_REV && rd_idx[0]) |-> rd_data == FW_REV[15:8])
    else $error("firmware revision high byte wrong");
  fw_ro_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && wr.cmd == pmc_pkg::CMD_FW_REV) |=> inv_q)
    else $error("firmware revision write not refused");
  ara_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
    (alert_active && ara_q[4]) |-> resp_addr == 8'h0c)
    else $error("alert response address not used");
  pg_sense_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pol_q[0] == 1'b0) |-> power_good_out == !power_good_out_int)
    else $error("power good polarity wrong");
  pol_ro_a: assert property (@(posedge clk_sys) disable iff (rst)
    pol_q[7:1] == 7'h00)
    else $error("polarity reserved bits set");
  dls_prot_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_byte && wpe_q && wr.cmd == pmc_pkg::CMD_DLS && wr.idx == 4'd0)
    |=> $stable(dls_q[0]))
    else $error("protected identity byte changed");
  wpe_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && wr.cmd == pmc_pkg::CMD_DEV_TYPE) |=> wpe_q == $past(word_q[1]))
    else $error("write protect bit not taken");
  inv_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (inv_q && !fault_clear) |=> inv_q)
    else $error("invalid data flag lost");
  dls_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && !wpe_q && wr.cmd == pmc_pkg::CMD_DLS && bad_q) |=> inv_q)
    else $error("out of range identity byte not flagged");
  cal_reject_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && !wpe_q && wr.cmd == pmc_pkg::CMD_VOUT_GAIN && word_q > 16'h2666)
    |=> inv_q && $stable(vout_gain))
    else $error("out of range gain accepted");
  exp_vout_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_end && !wpe_q && wr.cmd == pmc_pkg::CMD_VOUT_OFS && word_q[15:11] != 5'h14)
    |=> inv_q)
    else $error("bad vout offset exponent accepted");

  cal_write_c: cover property (@(posedge clk_sys) wr_end && is_cal && ok && !wpe_q);
  prot_write_c: cover property (@(posedge clk_sys) wr_end && prot && wpe_q);
  ara_use_c: cover property (@(posedge clk_sys) alert_active && ara_q[4]);
  fw_write_c: cover property (@(posedge clk_sys) wr_end && wr.cmd == pmc_pkg::CMD_FW_REV);
  dls_full_c: cover property (@(posedge clk_sys) wr_byte && wr.cmd == pmc_pkg::CMD_DLS
                              && wr.idx == 4'd11);

endmodule : pmc_mfr_regs
`default_nettype wire

//--- design/pmc_pkg.sv
package pmc_pkg;

  // command codes
  localparam logic [7:0] CMD_DEV_TYPE   = 8'hd0;
  localparam logic [7:0] CMD_VOUT_GAIN  = 8'hd1;
  localparam logic [7:0] CMD_VOUT_OFS   = 8'hd2;
  localparam logic [7:0] CMD_VIN_GAIN   = 8'hd3;
  localparam logic [7:0] CMD_VIN_OFS    = 8'hd4;
  localparam logic [7:0] CMD_IOUT_GAIN  = 8'hd6;
  localparam logic [7:0] CMD_IOUT_OFS   = 8'hd7;
  localparam logic [7:0] CMD_FW_REV     = 8'hdb;
  localparam logic [7:0] CMD_ARA_CFG    = 8'he0;
  localparam logic [7:0] CMD_PG_POL     = 8'he2;
  localparam logic [7:0] CMD_DLS        = 8'hf0;

  // limits and reset values
  localparam logic [15:0] GAIN_MAX      = 16'h2666;
  localparam logic [15:0] GAIN_MIN      = 16'h1999;
  localparam logic [15:0] GAIN_RST      = 16'h2000;
  localparam logic [15:0] OFS_RST       = 16'h0000;
  localparam logic [4:0]  EXP_VOUT      = 5'h14;
  localparam logic [4:0]  EXP_VIN       = 5'h1d;
  localparam logic [4:0]  EXP_IOUT      = 5'h1c;
  localparam logic [7:0]  ARA_RST       = 8'h00;
  localparam logic [7:0]  PG_POL_RST    = 8'h01;
  localparam logic [7:0]  ARA_MASK      = 8'h1f;
  localparam int          ARA_BIT       = 4;
  localparam int          PG_POL_BIT    = 0;
  localparam int          WPE_BIT       = 1;
  localparam int          NAME_LSB      = 2;
  localparam int          INV_DATA_BIT  = 6;
  localparam int          DLS_BYTES     = 12;
  localparam logic [7:0]  SMB_ARA_ADDR  = 8'h0c;

  // one write byte of a command transaction from the smbus byte engine
  typedef struct packed {
    logic [7:0]  cmd;
    logic [3:0]  idx;
    logic [7:0]  data;
  } pmc_wr_s;

endpackage : pmc_pkg

//--- design/pmc_cal_check.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_cal_check (
  input  wire logic [7:0]  cmd,    // command code
  input  wire logic [15:0] word,   // assembled data word
  output logic             valid   // value within limits
);
  always_comb begin
    unique case (cmd)
      pmc_pkg::CMD_VOUT_GAIN, pmc_pkg::CMD_VIN_GAIN, pmc_pkg::CMD_IOUT_GAIN:
        valid = (word >= pmc_pkg::GAIN_MIN) && (word <= pmc_pkg::GAIN_MAX);
      pmc_pkg::CMD_VOUT_OFS:
        valid = (word[15:11] == pmc_pkg::EXP_VOUT);
      pmc_pkg::CMD_VIN_OFS:
        valid = (word[15:11] == pmc_pkg::EXP_VIN);  // linear11
      pmc_pkg::CMD_IOUT_OFS:
        valid = (word[15:11] == pmc_pkg::EXP_IOUT);
      default:
        valid = 1'b1;
    endcase
  end
endmodule : pmc_cal_check
`default_nettype wire

//--- dv/pmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_host (
  input  wire logic      clk_sys,     // device clock
  input  wire logic [7:0] rd_data,    // read byte from the device
  output logic           wr_byte,     // data byte strobe
  output logic           wr_end,      // end of write
  output pmc_pkg::pmc_wr_s wr,        // command, index, byte
  output logic [7:0]     rd_cmd,      // read command
  output logic [3:0]     rd_idx,      // read byte index
  output logic           fault_clear  // clear faults pulse
);
  initial begin
    wr_byte = 1'b0;
    wr_end = 1'b0;
    wr = '0;
    rd_cmd = 8'h00;
    rd_idx = 4'h0;
    fault_clear = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // low byte first; gains and exponents are sent as given, out-of-range values included
  task automatic send(input logic [7:0] cmd, input int first, input int n,
                      input logic [95:0] d);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      wr_byte = 1'b1;
      wr = '{cmd: cmd, idx: 4'(first + i), data: d[8*i+:8]};
    end
    @(negedge clk_sys);
    wr_byte = 1'b0;
    wr_end = 1'b1;
    @(negedge clk_sys);
    wr_end = 1'b0;
    // idle bus shows a changing pattern, not the last byte
    wr = '{cmd: 8'h00, idx: 4'hf, data: ~wr.data};
  endtask : send
  task automatic get(input logic [7:0] cmd, input logic [3:0] idx, output logic [7:0] b);
    @(negedge clk_sys);
    rd_cmd = cmd;
    rd_idx = idx;
    #1 b = rd_data;
  endtask : get
  task automatic clr();
    @(negedge clk_sys);
    fault_clear = 1'b1;
    @(negedge clk_sys);
    fault_clear = 1'b0;
  endtask : clr
endmodule : pmc_host
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, alert_active = 1'b0, power_good_out_int = 1'b1;
  logic [7:0] strap_addr = 8'h5a;
  logic wr_byte, wr_end, fault_clear, power_good_out, write_protect_on, inv_data;
  pmc_pkg::pmc_wr_s wr;
  logic [7:0] rd_cmd, rd_data, resp_addr, b, lo, hi;
  logic [3:0] rd_idx;
  logic [15:0] vout_gain, vout_ofs, vin_gain, vin_ofs, iout_gain, iout_ofs;
  int error_cnt = 0, tests_run = 0;
  localparam logic [7:0] GCMD [3] = '{8'hd1, 8'hd3, 8'hd6};
  localparam logic [7:0] OCMD [3] = '{8'hd2, 8'hd4, 8'hd7};
  localparam logic [4:0] OEXP [3] = '{5'h14, 5'h1d, 5'h1c};
  localparam logic [95:0] ID = 96'hc1b2a3948576_6758493a2b1c;
  pmc_mfr_regs #(.FW_REV(16'h3507), .MOD_NAME(6'h2b)) u_dut ( // arbitrary values
    .clk_sys, .rst, .wr_byte, .wr_end, .wr, .rd_cmd, .rd_idx, .fault_clear,
    .alert_active, .strap_addr, .power_good_out_int, .rd_data, .resp_addr, .power_good_out,
    .write_protect_on, .inv_data, .vout_gain, .vout_ofs, .vin_gain, .vin_ofs,
    .iout_gain, .iout_ofs);
  pmc_host u_host (.clk_sys, .rd_data, .wr_byte, .wr_end, .wr, .rd_cmd, .rd_idx,
    .fault_clear);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdw(input logic [7:0] cmd, input logic [15:0] exp);
    u_host.get(cmd, 4'h0, lo);
    u_host.get(cmd, 4'h1, hi);
    chk({hi, lo}, exp);
  endtask : rdw
  task automatic sw(input logic [7:0] cmd, input logic [15:0] w);
    u_host.send(cmd, 0, 2, {80'h0, w});
  endtask : sw
  task automatic summarize();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #200000 error_cnt++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    rdw(8'hd0, 16'h00ac);
    for (int i = 0; i < 3; i++) begin
      rdw(GCMD[i], 16'h2000);
      rdw(OCMD[i], 16'h0000);
      sw(GCMD[i], 16'h1999);
      rdw(GCMD[i], 16'h1999);
      sw(GCMD[i], 16'h2667);
      chk(inv_data, 1'b1);
      rdw(GCMD[i], 16'h1999);
      u_host.clr();
      chk(inv_data, 1'b0);
      sw(GCMD[i], 16'h2666);
      sw(GCMD[i], 16'h1998);
      rdw(GCMD[i], 16'h2666);
      u_host.clr();
      sw(OCMD[i], {OEXP[i], 11'h123});
      rdw(OCMD[i], {OEXP[i], 11'h123});
      sw(OCMD[i], {OEXP[i] ^ 5'h01, 11'h007});
      chk(inv_data, 1'b1);
      rdw(OCMD[i], {OEXP[i], 11'h123});
      u_host.clr();
    end
    chk(vout_ofs, {5'h14, 11'h123});
    chk(vin_gain, 16'h2666);
    chk(vin_ofs, {5'h1d, 11'h123});
    chk(iout_gain, 16'h2666);
    chk(iout_ofs, {5'h1c, 11'h123});
    // locked: calibration and identity writes vanish without a flag
    sw(8'hd0, 16'hffff);
    chk(write_protect_on, 1'b1);
    rdw(8'hd0, 16'h00ae);
    sw(8'hd1, 16'h2100);
    u_host.send(8'hf0, 0, 12, ID);
    rdw(8'hd1, 16'h2666);
    u_host.get(8'hf0, 4'h0, b);
    chk(b, 8'h00);
    chk(inv_data, 1'b0);
    sw(8'hd0, 16'h0000);
    chk(write_protect_on, 1'b0);
    sw(8'hd1, 16'h2100);
    chk(vout_gain, 16'h2100);
    u_host.send(8'hf0, 0, 12, ID);
    for (int i = 0; i < 12; i++) begin
      u_host.get(8'hf0, 4'(i), b);
      chk(b, ID[8*i+:8]);
    end
    u_host.send(8'hf0, 12, 1, 96'h55);
    chk(inv_data, 1'b1);
    u_host.clr();
    // a refused block write must leave nothing behind for the next one
    u_host.send(8'hf0, 5, 1, 96'h77);
    chk(inv_data, 1'b0);
    u_host.get(8'hf0, 4'h5, b);
    chk(b, 8'h77);
    rdw(8'hdb, 16'h3507);
    sw(8'hdb, 16'h0000);
    chk(inv_data, 1'b1);
    rdw(8'hdb, 16'h3507);
    u_host.clr();
    u_host.get(8'he0, 4'h0, b);
    chk(b, 8'h00);
    @(negedge clk_sys) alert_active = 1'b1;
    #1 chk(resp_addr, 8'h5a);
    u_host.send(8'he0, 0, 1, 96'hff);
    u_host.get(8'he0, 4'h0, b);
    chk(b, 8'h1f);
    chk(resp_addr, 8'h0c);
    @(negedge clk_sys) alert_active = 1'b0;
    #1 chk(resp_addr, 8'h5a);
    u_host.get(8'he2, 4'h0, b);
    chk({b, 7'h0, power_good_out}, 16'h0101);
    u_host.send(8'he2, 0, 1, 96'hfe);
    u_host.get(8'he2, 4'h0, b);
    chk({b, 7'h0, power_good_out}, 16'h0000);
    @(negedge clk_sys) power_good_out_int = 1'b0;
    #1 chk(power_good_out, 1'b1);
    // mid-run reset restores defaults
    @(negedge clk_sys) rst = 1'b1;
    @(negedge clk_sys) rst = 1'b0;
    chk(vout_gain, 16'h2000);
    chk(power_good_out, 1'b0);
    u_host.get(8'hf0, 4'h0, b);
    chk(b, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
